// *** pmr_top.sv ***
// power management register bank with apb slave and enable outputs
// assumes apb master on pclk; enables feed the powered sub-blocks
//
// Function
// - dac standby bit 15 of analog register one resets to 1; 0 puts dacs in low power.
// - reference buffer bit 13 powers the analog reference, resetting to 0.
// - bits 10 and 9 power the right and left channels of the first adc.
// - bits 6 and 5 power the right and left third auxiliary dac channels.
// - bits 1 and 0 power the right and left first auxiliary dac channels.
// - analog register two resets to zero and bit 9 powers the pll.
// - bits 3 and 2 of analog register two power the headphone dac channels.
// - bits 1 and 0 of analog register two power the headphone amplifiers.
// - digital register resets to zero; bits 4 and 3 power the rate converters.
// - digital bit 7 powers the pwm channels.
// - digital bit 6 powers the s/pdif transmitter.
// - digital bit 1 powers the conversion engine.
// - digital bit 0 powers the processor core, resetting to 0.
//
// The implementer's own choice: the APB slave port.
module pmr_top
	import pmr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PMR_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [2:0] pprot,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic dac_normal_mode,
	output logic ref_buf_pwr,
	output logic first_adc_right_pwr,
	output logic first_adc_left_pwr,
	output logic third_auxiliary_dac_right_pwr,
	output logic third_auxiliary_dac_left_pwr,
	output logic first_auxiliary_dac_right_pwr,
	output logic first_auxiliary_dac_left_pwr,
	output logic pll_pwr,
	output logic headphone_dac_right_pwr,
	output logic headphone_dac_left_pwr,
	output logic headphone_amplifier_right_pwr,
	output logic headphone_amplifier_left_pwr,
	output logic pwm_pwr,
	output logic spdif_tx_pwr,
	output logic second_rate_converter_pwr,
	output logic first_rate_converter_pwr,
	output logic conv_engine_pwr,
	output logic core_pwr
);
	pmr_wr_if wr ();
	pmr_sel_e sel;
	logic access;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;

	function automatic pmr_sel_e pmr_decode(input logic [PMR_ADDR_W-1:0] a);
		case (a)
			PMR_ADDR_ANA1: return PMR_SEL_ANA1;
			PMR_ADDR_ANA2: return PMR_SEL_ANA2;
			PMR_ADDR_DIG: return PMR_SEL_DIG;
			default: return PMR_SEL_NONE;
		endcase
	endfunction

	assign sel = pmr_decode(paddr);
	// zero-wait slave: answer in the first access cycle
	assign access = psel && penable;
	assign pready = 1'b1;

	// writes with pstrb lanes 0..1 both set update the 16-bit register
	assign wr.wr_stb = access && pwrite && sel != PMR_SEL_NONE &&
		pstrb[1:0] == 2'h3;
	assign wr.wr_sel = sel;
	assign wr.wr_data = pwdata[15:0];

	pmr_store u_store (
		.pclk(pclk),
		.presetn(presetn),
		.wr(wr)
	);

	always_comb begin
		nxt_prdata = 32'h0000_0000;
		case (sel)
			PMR_SEL_ANA1: nxt_prdata = {16'h0000, wr.ana1};
			PMR_SEL_ANA2: nxt_prdata = {16'h0000, wr.ana2};
			PMR_SEL_DIG: nxt_prdata = {16'h0000, wr.dig};
			default: nxt_prdata = 32'h0000_0000;
		endcase
	end

	// read data loaded at the end of a read setup cycle, so it stands
	// through the access cycle; zero in every other cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_ff <= nxt_prdata;
		end else begin
			prdata_ff <= 32'h0000_0000;
		end
	end

	assign prdata = prdata_ff;

	// unmapped address answers with an error
	assign pslverr = access && sel == PMR_SEL_NONE;

	// enables come straight from the register flops
	always_comb begin
		dac_normal_mode = wr.ana1[PMR_A1_DAC_NORMAL];
		ref_buf_pwr = wr.ana1[PMR_A1_REF_BUF];
		first_adc_right_pwr = wr.ana1[PMR_A1_ADC_R];
		first_adc_left_pwr = wr.ana1[PMR_A1_ADC_L];
		third_auxiliary_dac_right_pwr = wr.ana1[PMR_A1_AUX3_R];
		third_auxiliary_dac_left_pwr = wr.ana1[PMR_A1_AUX3_L];
		first_auxiliary_dac_right_pwr = wr.ana1[PMR_A1_AUX1_R];
		first_auxiliary_dac_left_pwr = wr.ana1[PMR_A1_AUX1_L];
		pll_pwr = wr.ana2[PMR_A2_PLL];
		headphone_dac_right_pwr = wr.ana2[PMR_A2_HPDAC_R];
		headphone_dac_left_pwr = wr.ana2[PMR_A2_HPDAC_L];
		headphone_amplifier_right_pwr = wr.ana2[PMR_A2_HPAMP_R];
		headphone_amplifier_left_pwr = wr.ana2[PMR_A2_HPAMP_L];
		pwm_pwr = wr.dig[PMR_D_PWM];
		spdif_tx_pwr = wr.dig[PMR_D_SPDIF];
		second_rate_converter_pwr = wr.dig[PMR_D_RATE2];
		first_rate_converter_pwr = wr.dig[PMR_D_RATE1];
		conv_engine_pwr = wr.dig[PMR_D_ENGINE];
		core_pwr = wr.dig[PMR_D_CORE];
	end
endmodule

// *** pmr_pkg.sv ***
// constants for the power management register bank
// assumes an apb slave with 32-bit data and word-aligned registers
package pmr_pkg;
	localparam int PMR_ADDR_W = 12;
	// printed offsets are register indices; byte address is four times
	localparam logic [PMR_ADDR_W-1:0] PMR_IDX_ANA1 = 12'h005;
	localparam logic [PMR_ADDR_W-1:0] PMR_IDX_ANA2 = 12'h006;
	localparam logic [PMR_ADDR_W-1:0] PMR_IDX_DIG = 12'h007;
	localparam logic [PMR_ADDR_W-1:0] PMR_ADDR_ANA1 = 12'h014;
	localparam logic [PMR_ADDR_W-1:0] PMR_ADDR_ANA2 = 12'h018;
	localparam logic [PMR_ADDR_W-1:0] PMR_ADDR_DIG = 12'h01c;
	localparam logic [15:0] PMR_RST_ANA1 = 16'h8000;
	localparam logic [15:0] PMR_RST_ANA2 = 16'h0000;
	localparam logic [15:0] PMR_RST_DIG = 16'h0000;
	// writable bits; all other positions are reserved
	localparam logic [15:0] PMR_MASK_ANA1 = 16'ha663;
	localparam logic [15:0] PMR_MASK_ANA2 = 16'h020f;
	localparam logic [15:0] PMR_MASK_DIG = 16'h00db;
	// analog register one fields
	localparam int PMR_A1_DAC_NORMAL = 15;
	localparam int PMR_A1_REF_BUF = 13;
	localparam int PMR_A1_ADC_R = 10;
	localparam int PMR_A1_ADC_L = 9;
	localparam int PMR_A1_AUX3_R = 6;
	localparam int PMR_A1_AUX3_L = 5;
	localparam int PMR_A1_AUX1_R = 1;
	localparam int PMR_A1_AUX1_L = 0;
	// analog register two fields
	localparam int PMR_A2_PLL = 9;
	localparam int PMR_A2_HPDAC_R = 3;
	localparam int PMR_A2_HPDAC_L = 2;
	localparam int PMR_A2_HPAMP_R = 1;
	localparam int PMR_A2_HPAMP_L = 0;
	// digital register fields
	localparam int PMR_D_PWM = 7;
	localparam int PMR_D_SPDIF = 6;
	localparam int PMR_D_RATE2 = 4;
	localparam int PMR_D_RATE1 = 3;
	localparam int PMR_D_ENGINE = 1;
	localparam int PMR_D_CORE = 0;
	typedef enum logic [1:0] {
		PMR_SEL_NONE,
		PMR_SEL_ANA1,
		PMR_SEL_ANA2,
		PMR_SEL_DIG
	} pmr_sel_e;
endpackage

// *** pmr_wr_if.sv ***
// write path from the bus slave to the register store
// assumes one clock domain; a write strobe lasts one cycle
interface pmr_wr_if;
	import pmr_pkg::*;
	logic wr_stb;
	pmr_sel_e wr_sel;
	logic [15:0] wr_data;
	logic [15:0] ana1;
	logic [15:0] ana2;
	logic [15:0] dig;
	modport bus (output wr_stb, output wr_sel, output wr_data,
		input ana1, input ana2, input dig);
	modport store (input wr_stb, input wr_sel, input wr_data,
		output ana1, output ana2, output dig);
endinterface

// *** pmr_store.sv ***
// holds the three power registers
// assumes writes arrive as one-cycle strobes from the bus slave
module pmr_store
	import pmr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	pmr_wr_if.store wr
);
	logic [15:0] ana1_ff;
	logic [15:0] ana2_ff;
	logic [15:0] dig_ff;

	// reserved positions never store a one
	function automatic logic [15:0] pmr_keep(input logic [15:0] d,
		input logic [15:0] m);
		return d & m;
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ana1_ff <= PMR_RST_ANA1;
		end else if (wr.wr_stb && wr.wr_sel == PMR_SEL_ANA1) begin
			ana1_ff <= pmr_keep(wr.wr_data, PMR_MASK_ANA1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ana2_ff <= PMR_RST_ANA2;
		end else if (wr.wr_stb && wr.wr_sel == PMR_SEL_ANA2) begin
			ana2_ff <= pmr_keep(wr.wr_data, PMR_MASK_ANA2);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dig_ff <= PMR_RST_DIG;
		end else if (wr.wr_stb && wr.wr_sel == PMR_SEL_DIG) begin
			dig_ff <= pmr_keep(wr.wr_data, PMR_MASK_DIG);
		end
	end

	assign wr.ana1 = ana1_ff;
	assign wr.ana2 = ana2_ff;
	assign wr.dig = dig_ff;
endmodule

// *** pmr_top_props.sv ***
// checker for the power register bank
// bound into pmr_top; sees only its ports
module pmr_top_props
	import pmr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PMR_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic dac_normal_mode,
	input wire logic ref_buf_pwr,
	input wire logic first_adc_right_pwr,
	input wire logic first_adc_left_pwr,
	input wire logic third_auxiliary_dac_right_pwr,
	input wire logic third_auxiliary_dac_left_pwr,
	input wire logic first_auxiliary_dac_right_pwr,
	input wire logic first_auxiliary_dac_left_pwr,
	input wire logic pll_pwr,
	input wire logic headphone_dac_right_pwr,
	input wire logic headphone_dac_left_pwr,
	input wire logic headphone_amplifier_right_pwr,
	input wire logic headphone_amplifier_left_pwr,
	input wire logic pwm_pwr,
	input wire logic spdif_tx_pwr,
	input wire logic second_rate_converter_pwr,
	input wire logic first_rate_converter_pwr,
	input wire logic conv_engine_pwr,
	input wire logic core_pwr
);
	logic [15:0] a1, a2, dg, rexp;
	logic acc, wok, map;
	assign a1 = {dac_normal_mode, 1'h0, ref_buf_pwr, 2'h0, first_adc_right_pwr,
		first_adc_left_pwr, 2'h0, third_auxiliary_dac_right_pwr,
		third_auxiliary_dac_left_pwr, 3'h0, first_auxiliary_dac_right_pwr,
		first_auxiliary_dac_left_pwr};
	assign a2 = {6'h00, pll_pwr, 5'h00, headphone_dac_right_pwr,
		headphone_dac_left_pwr, headphone_amplifier_right_pwr,
		headphone_amplifier_left_pwr};
	assign dg = {8'h00, pwm_pwr, spdif_tx_pwr, 1'h0, second_rate_converter_pwr,
		first_rate_converter_pwr, 1'h0, conv_engine_pwr, core_pwr};
	assign acc = psel && penable;
	assign wok = acc && pwrite && pstrb[1:0] == 2'h3;
	assign map = paddr inside {PMR_ADDR_ANA1, PMR_ADDR_ANA2, PMR_ADDR_DIG};
	assign rexp = paddr == PMR_ADDR_ANA1 ? a1 : paddr == PMR_ADDR_ANA2 ? a2 :
		paddr == PMR_ADDR_DIG ? dg : 16'h0000;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence wr_to(a);
		wok && paddr == a;
	endsequence
	ana1_write_a: assert property (wr_to(PMR_ADDR_ANA1) |=>
		a1 == ($past(pwdata[15:0]) & PMR_MASK_ANA1)) else $error("ana1 bad");
	ana2_write_a: assert property (wr_to(PMR_ADDR_ANA2) |=>
		a2 == ($past(pwdata[15:0]) & PMR_MASK_ANA2)) else $error("ana2 bad");
	dig_write_a: assert property (wr_to(PMR_ADDR_DIG) |=>
		dg == ($past(pwdata[15:0]) & PMR_MASK_DIG)) else $error("dig bad");
	regs_hold_a: assert property (!(wok && map) |=>
		$stable({a1, a2, dg})) else $error("enable changed without write");
	read_data_a: assert property (acc && !pwrite |->
		prdata == {16'h0000, rexp}) else $error("read data bad");
	err_map_a: assert property (acc |-> pslverr == !map) else $error("err bad");
	idle_quiet_a: assert property (!acc |-> !pslverr && prdata == 32'h0)
		else $error("idle outputs bad");
	ready_acc_a: assert property (acc |-> pready) else $error("no ready");
	reset_val_a: assert property ($rose(presetn) |->
		{a1, a2, dg} == {PMR_RST_ANA1, PMR_RST_ANA2, PMR_RST_DIG})
		else $error("reset value bad");
endmodule

bind pmr_top pmr_top_props i_props (.*);

// *** power_management_registers_test.sv ***
// self-checking bench for the power register bank
// drives the apb port of pmr_top directly
module power_management_registers_test
	import pmr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, pready, pslverr, e;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	wire [15:0] o1, o2, od;
	int error_cnt = 0, num_checks = 0;
	logic [11:0] adr [3] = '{PMR_ADDR_ANA1, PMR_ADDR_ANA2, PMR_ADDR_DIG};
	logic [15:0] msk [3] = '{PMR_MASK_ANA1, PMR_MASK_ANA2, PMR_MASK_DIG};
	logic [15:0] rst [3] = '{PMR_RST_ANA1, PMR_RST_ANA2, PMR_RST_DIG};
	pmr_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .pprot(3'h0), .prdata, .pready, .pslverr,
		.dac_normal_mode(o1[15]), .ref_buf_pwr(o1[13]),
		.first_adc_right_pwr(o1[10]), .first_adc_left_pwr(o1[9]),
		.third_auxiliary_dac_right_pwr(o1[6]), .third_auxiliary_dac_left_pwr(o1[5]),
		.first_auxiliary_dac_right_pwr(o1[1]), .first_auxiliary_dac_left_pwr(o1[0]),
		.pll_pwr(o2[9]), .headphone_dac_right_pwr(o2[3]),
		.headphone_dac_left_pwr(o2[2]), .headphone_amplifier_right_pwr(o2[1]),
		.headphone_amplifier_left_pwr(o2[0]), .pwm_pwr(od[7]),
		.spdif_tx_pwr(od[6]), .second_rate_converter_pwr(od[4]),
		.first_rate_converter_pwr(od[3]), .conv_engine_pwr(od[1]),
		.core_pwr(od[0]));
	function automatic logic [15:0] outs(int i);
		return (i == 0 ? o1 : i == 1 ? o2 : od) & msk[i];
	endfunction
	task automatic check(input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic xfer(input logic [11:0] a, input logic w,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= w ? s : 4'h0;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rd = prdata;
		e = pslverr;
		penable <= 1'h0;
		if (n >= 20) begin
			error_cnt++;
			$display("BAD %0t no ready", $time);
			end_sim;
		end
	endtask
	task automatic idle;
		psel <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic t_reset;
		for (int i = 0; i < 3; i++) begin
			xfer(adr[i], 1'h0, 32'h0, 4'hf);
			check(rd, {16'h0, rst[i]});
			check(outs(i), rst[i]);
		end
		idle;
		$display("reset test done");
	endtask
	task automatic t_bits;
		logic [15:0] p [4] = '{16'hffff, 16'h5555, 16'haaaa, 16'h0000};
		for (int k = 0; k < 4; k++) begin
			for (int i = 0; i < 3; i++)
				xfer(adr[i], 1'h1, {16'hffff, p[(k + i) % 4] & msk[i]}, 4'hf);
			for (int i = 0; i < 3; i++) begin
				xfer(adr[i], 1'h0, 32'h0, 4'hf);
				check(rd, p[(k + i) % 4] & msk[i]);
				check(outs(i), p[(k + i) % 4] & msk[i]);
			end
		end
		idle;
		$display("bit test done");
	endtask
	task automatic t_refuse;
		xfer(12'h010, 1'h1, 32'hffff, 4'hf);
		check(e, 1'h1);
		xfer(PMR_ADDR_DIG, 1'h1, 32'h00ff, 4'h2);
		check(e, 1'h0);
		xfer(12'h010, 1'h0, 32'h0, 4'hf);
		check({e, rd}, {1'h1, 32'h0});
		xfer(PMR_ADDR_DIG, 1'h0, 32'h0, 4'hf);
		check(rd, 16'h5555 & PMR_MASK_DIG);
		xfer(PMR_ADDR_DIG, 1'h1, 32'hffff, 4'hf);
		xfer(PMR_ADDR_DIG, 1'h0, 32'h0, 4'hf);
		check(rd, PMR_MASK_DIG);
		idle;
		$display("refusal test done");
	endtask
	initial begin
		forever #50 pclk = ~pclk;
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_reset;
		t_bits;
		t_refuse;
		presetn <= 1'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_reset;
		end_sim;
	end
endmodule
